// file: mirq_top.v
/*
 * interrupt request and enable logic: external pin sampling, source
 * merging, enable gating, four-level priority and vector presentation.
 * assumes peripheral flags arrive as levels from their own blocks, timer
 * overflows as one-cycle pulses, and the core acknowledges with pulses.
 */
// The AXI4-Lite slave port is this design's own decision.
`default_nettype none
`include "mirq_regs.vh"

module mirq_top #(
  parameter STATE_CYCLES = 4'd1
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // axi4-lite register bus
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // external interrupt pins, active low
  input wire ext_pin_zero,
  input wire ext_pin_one,
  // timers 0 and 1
  input wire timer0_overflow,
  input wire timer0_mode3,
  input wire timer1_overflow,
  // timer 2 flags
  input wire timer2_overflow_flag,
  input wire timer2_external_flag,
  // counter array flags and enables
  input wire [4:0] module_event_flag,
  input wire [4:0] module_event_irq_enable,
  input wire array_counter_overflow_flag,
  input wire array_overflow_irq_enable,
  // serial port flags
  input wire receive_done_flag,
  input wire transmit_done_flag,
  // cpu core
  input wire irq_ack,
  input wire irq_return,
  output reg irq_req_r,
  output reg [15:0] irq_vector_r,
  output reg [1:0] irq_level_r,
  output reg [2:0] irq_source_r,
  // timer flags as seen by the core
  output wire timer0_overflow_flag,
  output wire timer1_overflow_flag
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  reg [7:0] interrupt_enable_reg;
  reg [6:0] priority_upper_reg;
  reg [6:0] priority_lower_reg;
  reg [1:0] ext_mode_r;
  reg t0_flag_r;
  reg t1_flag_r;
  reg [3:0] active_lvl_r;
  reg [3:0] state_cnt_r;
  reg [1:0] frame_cnt_r;
  reg [6:0] src_req;
  reg [6:0] src_en;
  reg win_any;
  reg [2:0] win_idx;
  reg [1:0] win_lvl;
  reg [15:0] win_vec;
  reg [1:0] act_top;
  reg preempt_ok;
  reg [31:0] rd_data;
  reg rd_hit;
  reg wr_hit;
  reg [1:0] lvl_i;
  integer i;
  integer j;
  wire frame_en;
  wire [1:0] ext_pins;
  wire [1:0] ext_flag;
  wire [1:0] ext_hw_clr;
  wire wr_en;
  wire [7:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire [7:0] rd_addr;
  wire wr_byte0;
  wire wr_ctrl;
  wire ack_ok;

  assign ext_pins = {ext_pin_one, ext_pin_zero};
  assign wr_byte0 = wr_en & wr_strb[0];
  assign wr_ctrl = wr_byte0 & (wr_addr == `MIRQ_ADDR_EXT_CTRL);
  assign ack_ok = irq_ack & irq_req_r;
  assign timer0_overflow_flag = t0_flag_r;
  assign timer1_overflow_flag = t1_flag_r;

  // ----------------------------------------------------------------
  // bus front end
  // ----------------------------------------------------------------
  mirq_axil #(
    .AW(`MIRQ_ADDR_W)
  ) u_axil (
    .clk(clk),
    .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr_r(wr_addr),
    .wr_data_r(wr_data),
    .wr_strb_r(wr_strb),
    .wr_hit(wr_hit),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  // ----------------------------------------------------------------
  // state time and frame divider
  // ----------------------------------------------------------------
  // frame_en pulses once every four state times
  always @(posedge clk) begin
    if (sys_rst) begin
      state_cnt_r <= 4'h0;
      frame_cnt_r <= 2'h0;
    end else if (state_cnt_r == STATE_CYCLES - 4'd1) begin
      state_cnt_r <= 4'h0;
      frame_cnt_r <= frame_cnt_r + 2'd1;
    end else begin
      state_cnt_r <= state_cnt_r + 4'd1;
    end
  end
  assign frame_en = (state_cnt_r == STATE_CYCLES - 4'd1) &&
                    (frame_cnt_r == `MIRQ_STATES_PER_FRAME);

  // ----------------------------------------------------------------
  // external pins, one sampler each
  // ----------------------------------------------------------------
  // a vector to an external source clears its edge flag
  assign ext_hw_clr[0] = ack_ok & (irq_source_r == `MIRQ_SRC_EXT0);
  assign ext_hw_clr[1] = ack_ok & (irq_source_r == `MIRQ_SRC_EXT1);

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ext
      mirq_ext u_ext (
        .clk(clk),
        .sys_rst(sys_rst),
        .frame_en(frame_en),
        .pin(ext_pins[g]),
        .trigger_mode(ext_mode_r[g]),
        .hw_clr(ext_hw_clr[g]),
        .sw_we(wr_ctrl),
        .sw_val(wr_data[`MIRQ_EXT_FLAG_LSB + g]),
        .flag_r(ext_flag[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // timer 0 and 1 overflow flags
  // ----------------------------------------------------------------
  // overflow sets, vector clears; no set in timer 0 mode 3.
  // a new overflow beats a clear in the same cycle
  always @(posedge clk) begin
    if (sys_rst) begin
      t0_flag_r <= 1'b0;
      t1_flag_r <= 1'b0;
    end else begin
      if (timer0_overflow & ~timer0_mode3) begin
        t0_flag_r <= 1'b1;
      end else if (wr_ctrl) begin
        t0_flag_r <= wr_data[`MIRQ_T0_FLAG_BIT];
      end else if (ack_ok & (irq_source_r == `MIRQ_SRC_T0)) begin
        t0_flag_r <= 1'b0;
      end
      if (timer1_overflow) begin
        t1_flag_r <= 1'b1;
      end else if (wr_ctrl) begin
        t1_flag_r <= wr_data[`MIRQ_T1_FLAG_BIT];
      end else if (ack_ok & (irq_source_r == `MIRQ_SRC_T1)) begin
        t1_flag_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // enable register, cleared by reset
  always @(posedge clk) begin
    if (sys_rst) begin
      interrupt_enable_reg <= `MIRQ_RST_ENABLE;
      priority_upper_reg <= `MIRQ_RST_PRIO;
      priority_lower_reg <= `MIRQ_RST_PRIO;
      ext_mode_r <= `MIRQ_RST_MODE;
    end else if (wr_byte0) begin
      case (wr_addr)
        `MIRQ_ADDR_ENABLE: interrupt_enable_reg <= wr_data[7:0];
        `MIRQ_ADDR_PRIO_UP: priority_upper_reg <= wr_data[6:0];
        `MIRQ_ADDR_PRIO_LO: priority_lower_reg <= wr_data[6:0];
        `MIRQ_ADDR_EXT_CTRL: ext_mode_r <= wr_data[`MIRQ_EXT_MODE_LSB +: 2];
        default: ext_mode_r <= ext_mode_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // source merging and enable gating
  // ----------------------------------------------------------------
  always @* begin
    src_req[`MIRQ_SRC_EXT0] = ext_flag[0];
    src_req[`MIRQ_SRC_T0] = t0_flag_r;
    src_req[`MIRQ_SRC_EXT1] = ext_flag[1];
    src_req[`MIRQ_SRC_T1] = t1_flag_r;
    src_req[`MIRQ_SRC_SER] = receive_done_flag | transmit_done_flag;
    // timer 2: overflow or external flag
    src_req[`MIRQ_SRC_T2] = timer2_overflow_flag | timer2_external_flag;
    // array: six flags, each behind its own enable
    src_req[`MIRQ_SRC_ARR] = (|(module_event_flag & module_event_irq_enable)) |
                             (array_counter_overflow_flag & array_overflow_irq_enable);
    // source enable and global enable both needed
    src_en = src_req & interrupt_enable_reg[6:0] &
             {`MIRQ_NSRC{interrupt_enable_reg[`MIRQ_BIT_GLOBAL]}};
  end

  // ----------------------------------------------------------------
  // priority resolver
  // ----------------------------------------------------------------
  // highest level wins; walking down with >= leaves the
  // lowest index among equals
  always @* begin
    win_any = 1'b0;
    win_idx = 3'd0;
    win_lvl = 2'd0;
    lvl_i = 2'd0;
    for (i = `MIRQ_NSRC - 1; i >= 0; i = i - 1) begin
      lvl_i = {priority_upper_reg[i], priority_lower_reg[i]};
      if (src_en[i] && (!win_any || lvl_i >= win_lvl)) begin
        win_any = 1'b1;
        win_idx = i[2:0];
        win_lvl = lvl_i;
      end
    end
  end

  always @* begin
    case (win_idx)
      `MIRQ_SRC_EXT0: win_vec = `MIRQ_VEC_EXT0;
      `MIRQ_SRC_T0: win_vec = `MIRQ_VEC_T0;
      `MIRQ_SRC_EXT1: win_vec = `MIRQ_VEC_EXT1;
      `MIRQ_SRC_T1: win_vec = `MIRQ_VEC_T1;
      `MIRQ_SRC_SER: win_vec = `MIRQ_VEC_SER;
      `MIRQ_SRC_T2: win_vec = `MIRQ_VEC_T2;
      default: win_vec = `MIRQ_VEC_ARR;
    endcase
  end

  // only a strictly higher level than any routine in service
  always @* begin
    act_top = 2'd0;
    for (j = 0; j < 4; j = j + 1) begin
      if (active_lvl_r[j]) begin
        act_top = j[1:0];
      end
    end
    preempt_ok = (active_lvl_r == 4'h0) || (win_lvl > act_top);
  end

  // ----------------------------------------------------------------
  // presentation to the core and in-service levels
  // ----------------------------------------------------------------
  // decided once a frame so all requests of one frame compete together;
  // a flag cleared mid-frame is withdrawn only at the next frame
  always @(posedge clk) begin
    if (sys_rst) begin
      irq_req_r <= 1'b0;
      irq_vector_r <= 16'h0000;
      irq_level_r <= 2'd0;
      irq_source_r <= 3'd0;
    end else if (ack_ok) begin
      irq_req_r <= 1'b0;
    end else if (frame_en) begin
      irq_req_r <= win_any & preempt_ok;
      irq_vector_r <= win_vec;
      irq_level_r <= win_lvl;
      irq_source_r <= win_idx;
    end
  end

  // ack pushes the level, return pops the highest
  always @(posedge clk) begin
    if (sys_rst) begin
      active_lvl_r <= 4'h0;
    end else if (ack_ok) begin
      active_lvl_r <= active_lvl_r | (4'h1 << irq_level_r);
    end else if (irq_return) begin
      active_lvl_r <= active_lvl_r & ~(4'h1 << act_top);
    end
  end

  // ----------------------------------------------------------------
  // register read and write decode
  // ----------------------------------------------------------------
  always @* begin
    rd_hit = 1'b1;
    rd_data = 32'h00000000;
    case (rd_addr)
      `MIRQ_ADDR_ENABLE: rd_data[7:0] = interrupt_enable_reg;
      `MIRQ_ADDR_PRIO_UP: rd_data[6:0] = priority_upper_reg;
      `MIRQ_ADDR_PRIO_LO: rd_data[6:0] = priority_lower_reg;
      `MIRQ_ADDR_EXT_CTRL: rd_data[5:0] = {t1_flag_r, t0_flag_r, ext_flag, ext_mode_r};
      `MIRQ_ADDR_STATUS: rd_data[14:0] = {src_req, active_lvl_r, irq_source_r, irq_req_r};
      default: rd_hit = 1'b0;
    endcase
  end

  // status is read-only; writes to it are answered with an error
  always @* begin
    case (wr_addr)
      `MIRQ_ADDR_ENABLE: wr_hit = 1'b1;
      `MIRQ_ADDR_PRIO_UP: wr_hit = 1'b1;
      `MIRQ_ADDR_PRIO_LO: wr_hit = 1'b1;
      `MIRQ_ADDR_EXT_CTRL: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

endmodule // mirq_top

`default_nettype wire

// file: mirq_regs.vh
/*
 * register map, field positions, reset values and constants of the
 * interrupt request block.
 * assumes byte addresses on an axi4-lite bus with 32-bit data.
 */
`ifndef MIRQ_REGS_VH
`define MIRQ_REGS_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define MIRQ_ADDR_W 8
`define MIRQ_ADDR_ENABLE 8'ha8
`define MIRQ_ADDR_PRIO_UP 8'hac
`define MIRQ_ADDR_PRIO_LO 8'hb0
`define MIRQ_ADDR_EXT_CTRL 8'hb4
`define MIRQ_ADDR_STATUS 8'hb8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MIRQ_RST_ENABLE 8'h00
`define MIRQ_RST_PRIO 7'h00
`define MIRQ_RST_MODE 2'h0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MIRQ_BIT_GLOBAL 7
`define MIRQ_EXT_MODE_LSB 0
`define MIRQ_EXT_FLAG_LSB 2
`define MIRQ_T0_FLAG_BIT 4
`define MIRQ_T1_FLAG_BIT 5

// ----------------------------------------------------------------
// source indices, in priority-within-level order
// ----------------------------------------------------------------
`define MIRQ_NSRC 7
`define MIRQ_SRC_EXT0 3'd0
`define MIRQ_SRC_T0 3'd1
`define MIRQ_SRC_EXT1 3'd2
`define MIRQ_SRC_T1 3'd3
`define MIRQ_SRC_SER 3'd4
`define MIRQ_SRC_T2 3'd5
`define MIRQ_SRC_ARR 3'd6

// ----------------------------------------------------------------
// vector addresses
// ----------------------------------------------------------------
`define MIRQ_VEC_EXT0 16'h0003
`define MIRQ_VEC_T0 16'h000b
`define MIRQ_VEC_EXT1 16'h0013
`define MIRQ_VEC_T1 16'h001b
`define MIRQ_VEC_SER 16'h0023
`define MIRQ_VEC_T2 16'h002b
`define MIRQ_VEC_ARR 16'h0033

// ----------------------------------------------------------------
// timing and bus response codes
// ----------------------------------------------------------------
`define MIRQ_STATES_PER_FRAME 2'd3
`define MIRQ_AXI_OKAY 2'b00
`define MIRQ_AXI_SLVERR 2'b10

`endif

// file: mirq_ext.v
/*
 * one external interrupt pin: frame sampler and request flag.
 * assumes the pin is synchronous to clk and frame_en pulses once per frame.
 */
`default_nettype none

module mirq_ext (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // timing
  input wire frame_en,
  // pin and mode
  input wire pin,
  input wire trigger_mode,
  // flag control
  input wire hw_clr,
  input wire sw_we,
  input wire sw_val,
  output reg flag_r
);

  reg samp_r;
  wire set_lvl;
  wire set_edge;
  wire set_ev;

  // ----------------------------------------------------------------
  // sampling
  // ----------------------------------------------------------------
  // once per frame
  always @(posedge clk) begin
    if (sys_rst) begin
      samp_r <= 1'b1;
    end else if (frame_en) begin
      samp_r <= pin;
    end
  end

  assign set_lvl = frame_en & ~pin & ~trigger_mode;
  // in level mode any low frame sample sets, so a five-state level is always seen
  assign set_edge = frame_en & ~pin & samp_r & trigger_mode;
  assign set_ev = set_lvl | set_edge;

  // ----------------------------------------------------------------
  // request flag
  // ----------------------------------------------------------------
  // pin activity sets the flag; set wins over any clear
  always @(posedge clk) begin
    if (sys_rst) begin
      flag_r <= 1'b0;
    end else if (set_ev) begin
      flag_r <= 1'b1;
    end else if (sw_we) begin
      flag_r <= sw_val;
    end else if (hw_clr & trigger_mode) begin
      flag_r <= 1'b0;
    end
  end

endmodule // mirq_ext

`default_nettype wire

// file: mirq_axil.v
/*
 * axi4-lite slave front end: turns bus writes into one-cycle
 * register strobes; reads pass the address straight through.
 * assumes the parent decodes the address and answers within the cycle.
 */
`default_nettype none
`include "mirq_regs.vh"

module mirq_axil #(
  parameter AW = 8
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // write address and data
  input wire [AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // read
  input wire [AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // register side
  output wire wr_en,
  output reg [AW-1:0] wr_addr_r,
  output reg [31:0] wr_data_r,
  output reg [3:0] wr_strb_r,
  input wire wr_hit,
  output wire [AW-1:0] rd_addr,
  input wire [31:0] rd_data,
  input wire rd_hit
);

  reg aw_full_r;
  reg w_full_r;

  // address and data are taken in either order, one write at a time
  assign s_axi_awready = ~aw_full_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_full_r & ~s_axi_bvalid;
  assign wr_en = aw_full_r & w_full_r;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_addr = s_axi_araddr;

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      wr_addr_r <= {AW{1'b0}};
      wr_data_r <= 32'h00000000;
      wr_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MIRQ_AXI_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_full_r <= 1'b1;
        wr_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_full_r <= 1'b1;
        wr_data_r <= s_axi_wdata;
        wr_strb_r <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `MIRQ_AXI_OKAY : `MIRQ_AXI_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read channel; data captured at the address handshake
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `MIRQ_AXI_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_hit ? rd_data : 32'h00000000;
      s_axi_rresp <= rd_hit ? `MIRQ_AXI_OKAY : `MIRQ_AXI_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // mirq_axil

`default_nettype wire

// file: mirl_sva.sv
/* port checker for the interrupt request block.
   assumes a bind onto mirq_top, one clock and a synchronous reset. */
`default_nettype none
module mirl_sva #(
  parameter STATE_CYCLES = 4'h1
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core side
  input wire logic irq_ack,
  input wire logic irq_req_r,
  input wire logic [15:0] irq_vector_r,
  input wire logic [2:0] irq_source_r,
  // timers
  input wire logic timer0_overflow,
  input wire logic timer0_mode3,
  input wire logic timer0_overflow_flag,
  input wire logic timer1_overflow,
  input wire logic timer1_overflow_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // vectoring steps
  sequence acked;
    irq_ack && irq_req_r;
  endsequence
  sequence t1_vectored;
    acked and (irq_source_r == 3'h3 && !timer1_overflow);
  endsequence
  AST_ACK_DROP: assert property (acked |=> !irq_req_r)
    else $error("request held after ack");
  AST_VEC_MAP: assert property (irq_req_r |-> irq_vector_r == {10'h0, irq_source_r, 3'h3})
    else $error("vector does not match source");
  AST_T0_SET: assert property (timer0_overflow && !timer0_mode3 |=> timer0_overflow_flag)
    else $error("timer 0 flag not set");
  AST_T1_CLR: assert property (t1_vectored |=> !timer1_overflow_flag)
    else $error("timer 1 flag kept after vectoring");
  AST_B_HOLD: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
    else $error("write response dropped early");
  AST_R_HOLD: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
    else $error("read data dropped early");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_W_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
endmodule // mirl_sva
bind mirq_top mirl_sva #(.STATE_CYCLES(STATE_CYCLES)) u_sva (.clk, .sys_rst, .s_axi_awready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .irq_ack, .irq_req_r, .irq_vector_r, .irq_source_r, .timer0_overflow, .timer0_mode3,
  .timer0_overflow_flag, .timer1_overflow, .timer1_overflow_flag);
`default_nettype wire

// file: mirl_partner.sv
/* far side: interrupt pin driver and core acknowledge.
   assumes its tasks are called just after a rising clock edge. */
`default_nettype none
module mirl_partner (
  // clock
  input wire logic clk,
  // pins, active low, idle high
  output logic ext_pin_zero,
  output logic ext_pin_one,
  // core handshake
  output logic irq_ack,
  output logic irq_return
);
  timeunit 1ns;
  timeprecision 1ns;
  // pins idle, core quiet
  initial begin
    ext_pin_zero = 1'h1;
    ext_pin_one = 1'h1;
    irq_ack = 1'h0;
    irq_return = 1'h0;
  end
  // idle, then long low on pin p
  task automatic pin_low(input bit p, input int n);
    repeat (4) @(posedge clk);
    if (p) ext_pin_one <= 1'h0;
    else ext_pin_zero <= 1'h0;
    repeat (n) @(posedge clk);
    ext_pin_zero <= 1'h1;
    ext_pin_one <= 1'h1;
  endtask
  task automatic service();
    @(posedge clk) irq_ack <= 1'h1;
    @(posedge clk) irq_ack <= 1'h0;
    repeat (3) @(posedge clk);
    irq_return <= 1'h1;
    @(posedge clk) irq_return <= 1'h0;
  endtask
endmodule // mirl_partner
`default_nettype wire

// file: tb_mcu_interrupt_request_logic.sv
/* self-checking bench for the interrupt request block.
   assumes mirq_top, its bound checker and the far-side model. */
`default_nettype none
module tb_mcu_interrupt_request_logic;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic timer0_overflow = '0, timer0_mode3 = '0, timer1_overflow = '0;
  logic timer2_overflow_flag = '0, timer2_external_flag = '0;
  logic array_counter_overflow_flag = '0, array_overflow_irq_enable = '0;
  logic receive_done_flag = '0, transmit_done_flag = '0;
  logic [4:0] module_event_flag = '0, module_event_irq_enable = '0;
  wire logic ext_pin_zero, ext_pin_one, irq_ack, irq_return, irq_req_r;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic timer0_overflow_flag, timer1_overflow_flag;
  wire logic [1:0] s_axi_bresp, s_axi_rresp, irq_level_r;
  wire logic [31:0] s_axi_rdata;
  wire logic [15:0] irq_vector_r;
  wire logic [2:0] irq_source_r;
  int bad_count = 0;
  int cmp_count = 0;
  mirq_top #(.STATE_CYCLES(4'h1)) dut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_pin_zero, .ext_pin_one, .timer0_overflow,
    .timer0_mode3, .timer1_overflow, .timer2_overflow_flag, .timer2_external_flag,
    .module_event_flag, .module_event_irq_enable, .array_counter_overflow_flag,
    .array_overflow_irq_enable, .receive_done_flag, .transmit_done_flag, .irq_ack, .irq_return,
    .irq_req_r, .irq_vector_r, .irq_level_r, .irq_source_r, .timer0_overflow_flag,
    .timer1_overflow_flag);
  mirl_partner u_far (.clk, .ext_pin_zero, .ext_pin_one, .irq_ack, .irq_return);
  // 100 ns period
  initial forever #50 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one bus transfer; sampled mid-cycle so the taking edge is known
  task automatic axi(input logic we, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic [1:0] r);
    logic ta, tw, td;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= we;
    s_axi_wvalid <= we;
    s_axi_arvalid <= !we;
    s_axi_bready <= we;
    s_axi_rready <= !we;
    do begin
      @(negedge clk);
      ta = we ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
      tw = s_axi_wvalid && s_axi_wready;
      td = we ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      r = we ? s_axi_bresp : s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (ta) s_axi_arvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end while (!td);
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [31:0] q;
    logic [1:0] r;
    axi(1'h1, a, d, q, r);
    chk(r, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] q;
    logic [1:0] r;
    axi(1'h0, a, 32'h0, q, r);
    chk(q, e);
    chk(r, er);
  endtask
  // bounded wait for a given vector on the core side
  task automatic wait_req(input logic [15:0] v);
    for (int n = 0; n < 40 && !(irq_req_r === 1'h1 && irq_vector_r === v); n++) @(negedge clk);
    chk({irq_req_r, irq_vector_r}, {1'h1, v});
  endtask
  task automatic quiet();
    repeat (12) @(negedge clk);
    chk(irq_req_r, 1'h0);
  endtask
  task automatic t_regs();
    rd(8'ha8, 32'h0, 2'h0);
    wr(8'ha8, 32'h5a, 2'h0);
    rd(8'ha8, 32'h5a, 2'h0);
    wr(8'hc0, 32'h1, 2'h2);
    rd(8'hc0, 32'h0, 2'h2);
  endtask
  task automatic t_ext();
    wr(8'hb4, 32'h1, 2'h0);
    wr(8'ha8, 32'h81, 2'h0);
    u_far.pin_low(1'h0, 6);
    wait_req(16'h0003);
    u_far.service();
    rd(8'hb4, 32'h1, 2'h0);
    wr(8'hb4, 32'h0, 2'h0);
    u_far.pin_low(1'h0, 6);
    wait_req(16'h0003);
    u_far.service();
    rd(8'hb4, 32'h4, 2'h0);
    wr(8'ha8, 32'h84, 2'h0);
    u_far.pin_low(1'h1, 6);
    wait_req(16'h0013);
    chk(irq_source_r, 3'h2);
    wr(8'ha8, 32'h0, 2'h0);
    wr(8'hb4, 32'h0, 2'h0);
  endtask
  task automatic t_timers();
    wr(8'ha8, 32'h08, 2'h0);
    @(posedge clk) timer1_overflow <= 1'h1;
    @(posedge clk) timer1_overflow <= 1'h0;
    quiet();
    wr(8'ha8, 32'h88, 2'h0);
    wait_req(16'h001b);
    u_far.service();
    chk(timer1_overflow_flag, 1'h0);
    timer0_mode3 <= 1'h1;
    @(posedge clk) timer0_overflow <= 1'h1;
    @(posedge clk) timer0_overflow <= 1'h0;
    @(negedge clk) chk(timer0_overflow_flag, 1'h0);
    @(posedge clk) timer0_mode3 <= 1'h0;
    @(posedge clk) timer0_overflow <= 1'h1;
    @(posedge clk) timer0_overflow <= 1'h0;
    @(negedge clk) chk(timer0_overflow_flag, 1'h1);
  endtask
  task automatic t_prio();
    wr(8'ha8, 32'hf0, 2'h0);
    receive_done_flag <= 1'h1;
    timer2_external_flag <= 1'h1;
    wait_req(16'h0023);
    wr(8'hac, 32'h20, 2'h0);
    wait_req(16'h002b);
    chk(irq_level_r, 2'h2);
    u_far.service();
    receive_done_flag <= 1'h0;
    timer2_external_flag <= 1'h0;
    module_event_flag <= 5'h1f;
    quiet();
    @(posedge clk) module_event_irq_enable <= 5'h10;
    wait_req(16'h0033);
    chk(irq_source_r, 3'h6);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'h0;
    t_regs();
    t_ext();
    t_timers();
    t_prio();
    conclude();
  end
  // hang guard, well past the few hundred cycles the run needs
  initial begin
    #300000;
    bad_count++;
    conclude();
  end
endmodule // tb_mcu_interrupt_request_logic
`default_nettype wire
